// [hdl/supcr_regs.v]
// Supply controller register block with APB slave and supply monitor pacing
`timescale 1ns/10ps
`default_nettype none
`include "supcr_defines.vh"

// What this block does
// - Control writes need key byte 0xA5
// - Write protect blocks control and mode writes
// - Regulator-off bit resets system, stops regulator
// - Crystal-select bit moves slow clock to crystal
// - Monitor sampling: off, continuous, 1/32, 1/256, 1/2048
// - Monitor reset enable routes detection to reset
// - Monitor interrupt enable routes detection to interrupt
// - Threshold field drives analog monitor code
// - LCD mode selects off, external or internal supply
// - LCD level field drives regulator adjust
// - Brownout reset enable routes detection to reset
// - Brownout disable bit turns detector off
// - Regulator-in-use bit selects internal regulator
// - Backup POR enable bit drives its output directly; state only reads back in status
// - Bypass crystal when bypass and crystal selected
// - Mode resets to 0x0000DA00, others zero
module supcr_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        slow_clock,
  input  wire        write_protect_enable,
  input  wire        monitor_detect,
  input  wire        brownout_detect,
  input  wire        backup_por_state,
  output reg         system_reset_req,
  output reg         regulator_stop,
  output reg         slow_clock_on_crystal,
  output reg         oscillator_bypassed,
  output reg         monitor_enable,
  output reg  [3:0]  monitor_threshold,
  output reg  [3:0]  lcd_regulator_level,
  output reg         external_lcd_supply,
  output reg         lcd_regulator_on,
  output reg         lcd_regulator_hiz,
  output reg         brownout_enable,
  output reg         regulator_in_use,
  output reg         backup_por_enable,
  output reg         irq
);

  reg  [31:0] mon_mode;
  reg  [31:0] mode;
  reg  [31:0] wake_mode;
  reg  [31:0] wake_inputs;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg         crystal_select;
  reg  [2:0]  slow_sync;
  reg  [1:0]  mon_sync;
  reg  [1:0]  bod_sync;
  reg  [1:0]  por_sync;
  reg         mon_det_q;
  reg         bod_det_q;
  reg  [11:0] smpl_cnt;
  reg  [11:0] smpl_period;
  reg  [31:0] next_prdata;

  wire wr_en   = psel & penable & pwrite;
  wire rd_en   = psel & penable & ~pwrite;
  wire wp_ok   = ~write_protect_enable;
  wire key_ok  = pwdata[`SUPCR_KEY_MSB:`SUPCR_KEY_LSB] ==
                 `SUPCR_KEY_MATCH_VALUE;
  wire slow_tick = slow_sync[1] & ~slow_sync[2];
  wire [2:0] smpl_mode = mon_mode[`SUPCR_MON_SMPL_MSB:`SUPCR_MON_SMPL_LSB];
  wire [1:0] lcd_mode  = mode[`SUPCR_LCD_MODE_MSB:`SUPCR_LCD_MODE_LSB];
  wire mon_rise = mon_sync[1] & ~mon_det_q;
  wire bod_rise = bod_sync[1] & ~bod_det_q;
  wire mon_event = mon_rise & monitor_enable;
  wire bod_event = bod_rise & brownout_enable;
  wire stat_rd = rd_en & (paddr == `SUPCR_OFF_IRQ_STATUS);

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a <= `SUPCR_OFF_IRQ_STATUS) && (a[1:0] == 2'b00);
    end
  endfunction

  always @* begin
    case (smpl_mode)
      `SUPCR_SMPL_32:   smpl_period = `SUPCR_PERIOD_32;
      `SUPCR_SMPL_256:  smpl_period = `SUPCR_PERIOD_256;
      `SUPCR_SMPL_2048: smpl_period = `SUPCR_PERIOD_2048;
      default:          smpl_period = 12'h000;
    endcase
  end

  // Read mux; control register is write-only and reads zero
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `SUPCR_OFF_MON_MODE:    next_prdata = mon_mode;
      `SUPCR_OFF_MODE:        next_prdata = mode;
      `SUPCR_OFF_WAKE_MODE:   next_prdata = wake_mode;
      `SUPCR_OFF_WAKE_INPUTS: next_prdata = wake_inputs;
      `SUPCR_OFF_STATUS: begin
        next_prdata[`SUPCR_BIT_BKP_POR_ST] = por_sync[1];
      end
      `SUPCR_OFF_IRQ_MASK:    next_prdata = {30'h0, irq_mask};
      `SUPCR_OFF_IRQ_STATUS:  next_prdata = {30'h0, irq_status};
      default:                next_prdata = 32'h0000_0000;
    endcase
  end

  // APB: one wait cycle, pready answers in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~is_mapped(paddr);
      if (rd_en & ~pready)
        prdata <= next_prdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sync <= 3'b000;
      mon_sync  <= 2'b00;
      bod_sync  <= 2'b00;
      por_sync  <= 2'b00;
      mon_det_q <= 1'b0;
      bod_det_q <= 1'b0;
    end else begin
      slow_sync <= {slow_sync[1:0], slow_clock};
      mon_sync  <= {mon_sync[0], monitor_detect};
      bod_sync  <= {bod_sync[0], brownout_detect};
      por_sync  <= {por_sync[0], backup_por_state};
      mon_det_q <= mon_sync[1];
      bod_det_q <= bod_sync[1];
    end
  end

  // Register writes take effect at the edge where pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_mode       <= `SUPCR_ZERO_RESET;
      mode           <= `SUPCR_MODE_RESET;
      wake_mode      <= `SUPCR_ZERO_RESET;
      wake_inputs    <= `SUPCR_ZERO_RESET;
      irq_mask       <= 2'b00;
      crystal_select <= 1'b0;
      regulator_stop <= 1'b0;
    end else if (wr_en & pready) begin
      case (paddr)
        `SUPCR_OFF_CONTROL:
          if (wp_ok & key_ok) begin
            if (pwdata[`SUPCR_BIT_REG_OFF])
              regulator_stop <= 1'b1;
            if (pwdata[`SUPCR_BIT_XTAL_SEL])
              crystal_select <= 1'b1;
          end
        `SUPCR_OFF_MON_MODE:
          if (wp_ok)
            mon_mode <= pwdata & `SUPCR_MON_MODE_MASK;
        `SUPCR_OFF_MODE:
          if (wp_ok)
            mode <= pwdata & `SUPCR_MODE_MASK;
        `SUPCR_OFF_WAKE_MODE:
          if (wp_ok)
            wake_mode <= pwdata & `SUPCR_WAKE_MODE_MASK;
        `SUPCR_OFF_WAKE_INPUTS:
          wake_inputs <= {3'b000, pwdata[28:0]};
        `SUPCR_OFF_IRQ_MASK:
          irq_mask <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Monitor pacing counts slow clock edges; counter restarts each period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smpl_cnt       <= 12'h000;
      monitor_enable <= 1'b0;
    end else begin
      case (smpl_mode)
        `SUPCR_SMPL_CONT: begin
          monitor_enable <= 1'b1;
          smpl_cnt       <= 12'h000;
        end
        `SUPCR_SMPL_32, `SUPCR_SMPL_256, `SUPCR_SMPL_2048: begin
          if (slow_tick) begin
            if (smpl_cnt >= smpl_period)
              smpl_cnt <= 12'h000;
            else
              smpl_cnt <= smpl_cnt + 12'h001;
            monitor_enable <= (smpl_cnt == 12'h000);
          end
        end
        default: begin
          monitor_enable <= 1'b0;
          smpl_cnt       <= 12'h000;
        end
      endcase
    end
  end

  // Sticky events: bit0 monitor (gated by its enable), bit1 brownout
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'b00;
      irq        <= 1'b0;
    end else begin
      // A new event wins over the clear-on-read in the same cycle
      irq_status <= (irq_status & {2{~(stat_rd & pready)}}) |
                    {bod_event,
                     mon_event & mon_mode[`SUPCR_BIT_MON_IRQ_EN]};
      irq <= |(irq_status & irq_mask);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset_req      <= 1'b0;
      slow_clock_on_crystal <= 1'b0;
      oscillator_bypassed   <= 1'b0;
      monitor_threshold     <= 4'h0;
      lcd_regulator_level   <= 4'h0;
      external_lcd_supply   <= 1'b0;
      lcd_regulator_on      <= 1'b0;
      lcd_regulator_hiz     <= 1'b0;
      brownout_enable       <= 1'b0;
      regulator_in_use      <= 1'b0;
      backup_por_enable     <= 1'b0;
    end else begin
      // Reset request holds until the system reset clears this block
      system_reset_req <= system_reset_req | regulator_stop |
        (mon_event & mon_mode[`SUPCR_BIT_MON_RST_EN]) |
        (bod_event & mode[`SUPCR_BIT_BOD_RST_EN]);
      slow_clock_on_crystal <= crystal_select;
      // Bypass only applies once crystal is picked; order is software's job
      oscillator_bypassed <= crystal_select &
                             mode[`SUPCR_BIT_OSC_BYPASS];
      monitor_threshold   <= mon_mode[`SUPCR_MON_THR_MSB:0];
      lcd_regulator_level <= mode[`SUPCR_LCD_LVL_MSB:0];
      external_lcd_supply <= (lcd_mode == `SUPCR_LCD_EXT);
      lcd_regulator_hiz   <= (lcd_mode == `SUPCR_LCD_EXT);
      lcd_regulator_on    <= (lcd_mode == `SUPCR_LCD_INT);
      brownout_enable     <= ~mode[`SUPCR_BIT_BOD_DIS];
      regulator_in_use    <= mode[`SUPCR_BIT_REG_IN_USE];
      backup_por_enable   <= mode[`SUPCR_BIT_BKP_POR_EN];
    end
  end

endmodule
`default_nettype wire

// [inc/supcr_defines.vh]
// Register map, field positions and reset values of the supply controller
`ifndef SUPCR_DEFINES_VH
`define SUPCR_DEFINES_VH
`define SUPCR_OFF_CONTROL      8'h00
`define SUPCR_OFF_MON_MODE     8'h04
`define SUPCR_OFF_MODE         8'h08
`define SUPCR_OFF_WAKE_MODE    8'h0c
`define SUPCR_OFF_WAKE_INPUTS  8'h10
`define SUPCR_OFF_STATUS       8'h14
`define SUPCR_OFF_IRQ_MASK     8'h18
`define SUPCR_OFF_IRQ_STATUS   8'h1c
`define SUPCR_KEY_MATCH_VALUE  8'ha5
`define SUPCR_KEY_MSB          31
`define SUPCR_KEY_LSB          24
`define SUPCR_BIT_REG_OFF      2
`define SUPCR_BIT_XTAL_SEL     3
`define SUPCR_MON_THR_MSB      3
`define SUPCR_MON_SMPL_MSB     10
`define SUPCR_MON_SMPL_LSB     8
`define SUPCR_BIT_MON_RST_EN   12
`define SUPCR_BIT_MON_IRQ_EN   13
`define SUPCR_LCD_LVL_MSB      3
`define SUPCR_LCD_MODE_MSB     5
`define SUPCR_LCD_MODE_LSB     4
`define SUPCR_BIT_BOD_RST_EN   12
`define SUPCR_BIT_BOD_DIS      13
`define SUPCR_BIT_REG_IN_USE   14
`define SUPCR_BIT_BKP_POR_EN   15
`define SUPCR_BIT_OSC_BYPASS   20
`define SUPCR_BIT_BKP_POR_ST   15
`define SUPCR_MON_MODE_MASK    32'h0000_370f
`define SUPCR_MODE_MASK        32'h0010_f03f
`define SUPCR_WAKE_MODE_MASK   32'h0307_7f0f
`define SUPCR_MODE_RESET       32'h0000_da00
`define SUPCR_ZERO_RESET       32'h0000_0000
`define SUPCR_SMPL_OFF         3'd0
`define SUPCR_SMPL_CONT        3'd1
`define SUPCR_SMPL_32          3'd2
`define SUPCR_SMPL_256         3'd3
`define SUPCR_SMPL_2048        3'd4
`define SUPCR_PERIOD_32        12'd31
`define SUPCR_PERIOD_256       12'd255
`define SUPCR_PERIOD_2048      12'd2047
`define SUPCR_LCD_OFF          2'd0
`define SUPCR_LCD_EXT          2'd2
`define SUPCR_LCD_INT          2'd3
`endif

// [tb/supcr_regs_props.sv]
// Concurrent checks on the supply controller register block ports
`timescale 1ns/10ps
`default_nettype none
module supcr_regs_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        write_protect_enable,
  input wire logic        system_reset_req,
  input wire logic        regulator_stop,
  input wire logic        slow_clock_on_crystal,
  input wire logic        oscillator_bypassed,
  input wire logic        external_lcd_supply,
  input wire logic        lcd_regulator_on,
  input wire logic        lcd_regulator_hiz,
  input wire logic        irq
);
  wire xfer   = psel && penable && pready;
  wire ctl_wr = xfer && pwrite && paddr == 8'h00;
  wire key_ok = pwdata[31:24] == 8'ha5;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lcd_src;
    external_lcd_supply == lcd_regulator_hiz
      && !(lcd_regulator_on && external_lcd_supply);
  endproperty
  a_lcd_src: assert property (p_lcd_src)
    else $error("lcd source outputs disagree");
  property p_stop_hold;
    regulator_stop |=> regulator_stop;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("regulator stop dropped");
  property p_stop_rst;
    $rose(regulator_stop) |-> ##[0:2] system_reset_req;
  endproperty
  a_stop_rst: assert property (p_stop_rst)
    else $error("regulator stop without system reset");
  property p_bad_key;
    ctl_wr && !key_ok && !slow_clock_on_crystal
      |=> (!slow_clock_on_crystal) [*2];
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("control write with wrong key acted");
  property p_protect;
    ctl_wr && write_protect_enable && !slow_clock_on_crystal
      |=> (!slow_clock_on_crystal) [*2];
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected control write acted");
  property p_xtal;
    ctl_wr && key_ok && !write_protect_enable && pwdata[3]
      |-> ##[1:3] slow_clock_on_crystal;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal select not applied");
  property p_bypass;
    oscillator_bypassed |-> slow_clock_on_crystal;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass without crystal selected");
  property p_ctl_read;
    xfer && !pwrite && paddr == 8'h00 |-> prdata == 32'h0000_0000;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control register read not zero");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_stop: cover property ($rose(regulator_stop));
endmodule
bind supcr_regs supcr_regs_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .write_protect_enable(write_protect_enable), .irq(irq),
  .system_reset_req(system_reset_req), .regulator_stop(regulator_stop),
  .slow_clock_on_crystal(slow_clock_on_crystal),
  .oscillator_bypassed(oscillator_bypassed),
  .external_lcd_supply(external_lcd_supply),
  .lcd_regulator_on(lcd_regulator_on), .lcd_regulator_hiz(lcd_regulator_hiz));
`default_nettype wire

// [tb/supcr_regs_tb_top.sv]
// Self-checking bench for the supply controller register block
`timescale 1ns/10ps
`default_nettype none
module supcr_regs_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, slow_clock, err, p;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, wpe, mon_det, bod_det, bpor, sys_rst;
  logic        reg_stop, on_xtal, bypassed, mon_en, ext_lcd, lcd_on;
  logic        lcd_hiz, bod_en, reg_use, bpor_en, irq;
  logic [3:0]  mon_thr, lcd_lvl;
  logic [2:0]  sdiv;
  integer      n_mismatch = 0, tests_run = 0, n;
  supcr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock(slow_clock), .write_protect_enable(wpe),
    .monitor_detect(mon_det), .brownout_detect(bod_det),
    .backup_por_state(bpor), .system_reset_req(sys_rst),
    .regulator_stop(reg_stop), .slow_clock_on_crystal(on_xtal),
    .oscillator_bypassed(bypassed), .monitor_enable(mon_en),
    .monitor_threshold(mon_thr), .lcd_regulator_level(lcd_lvl),
    .external_lcd_supply(ext_lcd), .lcd_regulator_on(lcd_on),
    .lcd_regulator_hiz(lcd_hiz), .brownout_enable(bod_en),
    .regulator_in_use(reg_use), .backup_por_enable(bpor_en), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Slow clock of eight bus cycles keeps the sampling test short
  always @(posedge pclk) begin
    sdiv <= sdiv + 3'd1;
    slow_clock <= sdiv[2];
  end
  task wt(input integer c);
    repeat (c) @(posedge pclk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    wt(3);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task do_reset;
    presetn <= 1'b0;
    wt(4);
    presetn <= 1'b1;
    wt(1);
  endtask
  // Events pass a synchroniser, so they are held well past its latency
  task pulse(input logic b);
    if (b) bod_det <= 1'b1;
    else mon_det <= 1'b1;
    wt(8);
    bod_det <= 1'b0;
    mon_det <= 1'b0;
    wt(8);
  endtask
  task rise_gap;
    n = 0;
    p = 1'b1;
    while (!(mon_en === 1'b1 && p === 1'b0) && n < 3000) begin
      p = mon_en;
      @(posedge pclk);
      n = n + 1;
    end
  endtask
  task t_reset;
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_da00);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    chk({bod_en, reg_use, bpor_en}, 32'h7);
    $display("test reset values done");
  endtask
  task t_mode;
    logic [1:0] m;
    for (m = 2'd0; m != 2'd1; m = m + 2'd1) begin
      wr(8'h08, 32'h0000_a005 | {m, 4'h0});
      chk({lcd_lvl, ext_lcd, lcd_hiz, lcd_on, bod_en, reg_use, bpor_en},
          {4'h5, m == 2'd2, m == 2'd2, m == 2'd3, 3'b001});
    end
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0010_f03f);
    wpe <= 1'b1;
    wr(8'h08, 32'h0000_0000);
    wr(8'h04, 32'h0000_370f);
    wpe <= 1'b0;
    rd(8'h08, 32'h0010_f03f);
    rd(8'h04, 32'h0000_0000);
    $display("test mode fields done");
  endtask
  task t_mon;
    wr(8'h04, 32'h0000_2109);
    chk({mon_thr, mon_en}, 32'h13);
    wr(8'h18, 32'h0000_0001);
    pulse(1'b0);
    chk(irq, 1'b1);
    rd(8'h1c, 32'h0000_0001);
    wt(2);
    chk(irq, 1'b0);
    wr(8'h18, 32'h0000_0000);
    pulse(1'b0);
    chk(irq, 1'b0);
    wr(8'h04, 32'h0000_0200);
    rise_gap;
    rise_gap;
    chk(n, 32'd256);
    wr(8'h04, 32'h0000_0000);
    chk(mon_en, 1'b0);
    $display("test monitor done");
  endtask
  task t_ctrl;
    wr(8'h00, 32'h5a00_0008);
    chk(on_xtal, 1'b0);
    wpe <= 1'b1;
    wr(8'h00, 32'ha500_0008);
    wpe <= 1'b0;
    chk(on_xtal, 1'b0);
    wr(8'h08, 32'h0010_0000);
    wr(8'h00, 32'ha500_0008);
    chk({on_xtal, bypassed}, 32'h3);
    rd(8'h00, 32'h0000_0000);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(err, 1'b1);
    chk(sys_rst, 1'b0);
    wr(8'h00, 32'ha500_0004);
    chk({reg_stop, sys_rst}, 32'h3);
    do_reset;
    $display("test control done");
  endtask
  task t_rstev;
    wr(8'h08, 32'h0000_0000);
    pulse(1'b1);
    chk(sys_rst, 1'b0);
    wr(8'h08, 32'h0000_1000);
    pulse(1'b1);
    chk(sys_rst, 1'b1);
    do_reset;
    wr(8'h04, 32'h0000_0100);
    pulse(1'b0);
    chk(sys_rst, 1'b0);
    wr(8'h04, 32'h0000_1100);
    pulse(1'b0);
    chk(sys_rst, 1'b1);
    do_reset;
    $display("test reset events done");
  endtask
  task complete_run;
    $display("mismatches %0d in %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, wpe, mon_det, bod_det, bpor} = 7'h00;
    {slow_clock, sdiv, paddr, pwdata, presetn} = 0;
    wt(4);
    presetn <= 1'b1;
    wt(1);
    t_reset;
    t_mode;
    t_mon;
    t_ctrl;
    t_rstev;
    complete_run;
  end
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
endmodule
`default_nettype wire
